// >>> uwl_pkg.sv
package uwl_pkg;
   localparam int unsigned XLEN          = 64;
   localparam int unsigned WLEN          = 32;
   localparam int unsigned REG_IDX_W     = 5;
   localparam logic [5:0]  OPC_LOAD_LEFT  = 6'h22;
   localparam logic [5:0]  OPC_LOAD_RIGHT = 6'h26;
   localparam int unsigned OPC_LSB       = 26;
   localparam int unsigned BASE_LSB      = 21;
   localparam int unsigned TARGET_LSB    = 16;
   localparam int unsigned OFFSET_W      = 16;
   localparam logic [3:0]  EXC_NONE      = 4'h0;
   localparam logic [3:0]  EXC_TLB_REFILL  = 4'h1;
   localparam logic [3:0]  EXC_TLB_INVALID = 4'h2;
   localparam logic [3:0]  EXC_BUS_ERROR   = 4'h3;
   localparam logic [3:0]  EXC_ADDR_ERROR  = 4'h4;
   localparam logic [3:0]  EXC_WATCH       = 4'h5;
   localparam logic [63:0] RESULT_RESET  = 64'h0;
   typedef enum logic [1:0] {OP_NONE, OP_LEFT, OP_RIGHT} load_op_t;
endpackage

// >>> byte_merge.sv
`timescale 1ns/100ps
`default_nettype none
// one partial-word merge, registered result
module byte_merge (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic        load_en,
   input  wire logic        is_left,
   input  wire logic        big_endian,
   input  wire logic        fill_sign,
   input  wire logic [1:0]  offset,
   input  wire logic [31:0] mem_word,
   input  wire logic [63:0] old_value,
   output logic      [63:0] merged
);
   import uwl_pkg::*;

   logic [1:0]  byte_sel;
   logic [31:0] word_next;
   logic [31:0] upper_next;
   logic        full_word;

   always_comb begin
      // byte-order swap folds into a single index
      byte_sel  = offset ^ {2{big_endian}};
      word_next = old_value[31:0];
      full_word = 1'b0;
      if (is_left) begin
         // fetched bytes fill the high end of the low word
         case (byte_sel)
            2'd0: word_next = {mem_word[7:0],  old_value[23:0]};
            2'd1: word_next = {mem_word[15:0], old_value[15:0]};
            2'd2: word_next = {mem_word[23:0], old_value[7:0]};
            default: word_next = mem_word;
         endcase
         full_word = 1'b1;
      end else begin
         // fetched bytes fill the low end of the low word
         case (byte_sel)
            2'd0: word_next = mem_word;
            2'd1: word_next = {old_value[31:24], mem_word[31:8]};
            2'd2: word_next = {old_value[31:16], mem_word[31:16]};
            default: word_next = {old_value[31:8], mem_word[31:24]};
         endcase
         full_word = (byte_sel == 2'd0);
      end
      // sign-filled for left loads, full right words or with fill_sign, else old upper half kept; never zero-filled
      if (full_word || fill_sign)
         upper_next = {WLEN{word_next[31]}};
      else
         upper_next = old_value[63:32];
   end

   always_ff @(posedge mclk) begin
      if (rst)
         merged <= RESULT_RESET;
      else if (ce && load_en)
         merged <= {upper_next, word_next};
   end
endmodule
`default_nettype wire

// >>> unaligned_word_load_merge.sv
`timescale 1ns/100ps
`default_nettype none
module unaligned_word_load_merge #(
   parameter bit SIGN_FILL_PARTIAL = 1'b0
) (
   input  wire logic                         mclk,
   input  wire logic                         rst,
   input  wire logic                         ce,
   input  wire logic                         instr_valid,
   input  wire logic [31:0]                  instr,
   input  wire logic [uwl_pkg::XLEN-1:0]     base_value,
   input  wire logic [uwl_pkg::XLEN-1:0]     target_value,
   input  wire logic                         processor_byte_order_big,
   input  wire logic                         mem_valid,
   input  wire logic [63:0]                  mem_doubleword,
   input  wire logic [3:0]                   mem_exception,
   output logic                              mem_req,
   output logic      [uwl_pkg::XLEN-1:0]     effective_byte_address,
   output logic                              wb_valid,
   output logic      [4:0]                   wb_index,
   output logic      [uwl_pkg::XLEN-1:0]     wb_data,
   output logic                              exc_valid,
   output logic      [3:0]                   exc_code,
   output logic                              busy
);
   import uwl_pkg::*;

   load_op_t          op_reg;
   logic [4:0]        target_reg_field;
   logic [XLEN-1:0]   old_reg;
   logic              order_reg;
   logic              merge_en;
   logic              merge_done;
   logic [63:0]       merged;
   logic [31:0]       mem_word;
   logic [5:0]        opcode;
   logic              is_partial;
   logic [XLEN-1:0]   virtual_address;
   logic              forward_hit;
   logic [XLEN-1:0]   old_next;
   logic [4:0]        instr_target;
   logic              accept;
   logic              answer;
   logic              merge_hit;

   function automatic logic [XLEN-1:0] sext_offset(input logic [15:0] off);
      sext_offset = {{(XLEN - OFFSET_W){off[15]}}, off};
   endfunction

   function automatic logic [4:0] target_of(input logic [31:0] word);
      target_of = word[TARGET_LSB +: REG_IDX_W];
   endfunction

   assign opcode       = instr[31:OPC_LSB];
   assign is_partial   = (opcode == OPC_LOAD_LEFT) || (opcode == OPC_LOAD_RIGHT);
   assign instr_target = target_of(instr);
   assign accept       = !busy && instr_valid && is_partial;
   assign answer       = busy && mem_valid;
   // no alignment check on partial loads
   assign virtual_address = base_value + sext_offset(instr[15:0]);

   // a load taken right after busy drops finds its predecessor still in the
   // merge register; one taken a cycle later finds it on the writeback port
   assign merge_hit   = merge_done && (target_reg_field == instr_target);
   assign forward_hit = wb_valid && (wb_index == instr_target);
   always_comb begin
      if (merge_hit)
         old_next = merged;
      else if (forward_hit)
         old_next = wb_data;
      else
         old_next = target_value;
   end

   // word half of the doubleword follows address bit 2 and byte order
   assign mem_word = (effective_byte_address[2] ^ order_reg) ?
                     mem_doubleword[63:32] : mem_doubleword[31:0];
   assign merge_en = answer && (mem_exception == EXC_NONE);

   // busy from accept to the memory answer; offers meanwhile are dropped
   always_ff @(posedge mclk) begin
      if (rst) begin
         busy <= 1'b0;
      end else if (ce) begin
         if (accept)
            busy <= 1'b1;
         else if (answer)
            busy <= 1'b0;
      end
   end

   // one-cycle request pulse
   always_ff @(posedge mclk) begin
      if (rst)
         mem_req <= 1'b0;
      else if (ce)
         mem_req <= accept;
   end

   // kind of load, held for the merge
   always_ff @(posedge mclk) begin
      if (rst)
         op_reg <= OP_NONE;
      else if (ce && accept)
         op_reg <= (opcode == OPC_LOAD_LEFT) ? OP_LEFT : OP_RIGHT;
   end

   // destination index travels with the load
   always_ff @(posedge mclk) begin
      if (rst)
         target_reg_field <= 5'h0;
      else if (ce && accept)
         target_reg_field <= instr_target;
   end

   // old value sampled once; later register file writes cannot reach it
   always_ff @(posedge mclk) begin
      if (rst)
         old_reg <= RESULT_RESET;
      else if (ce && accept)
         old_reg <= old_next;
   end

   // byte order frozen at accept, so a mode change mid-load is harmless
   always_ff @(posedge mclk) begin
      if (rst)
         order_reg <= 1'b0;
      else if (ce && accept)
         order_reg <= processor_byte_order_big;
   end

   // address held for memory and for byte selection
   always_ff @(posedge mclk) begin
      if (rst)
         effective_byte_address <= RESULT_RESET;
      else if (ce && accept)
         effective_byte_address <= virtual_address;
   end

   byte_merge merge_unit (
      .mclk       (mclk),
      .rst        (rst),
      .ce         (ce),
      .load_en    (merge_en),
      .is_left    (op_reg == OP_LEFT),
      .big_endian (order_reg),
      .fill_sign  (SIGN_FILL_PARTIAL),
      .offset     (effective_byte_address[1:0]),
      .mem_word   (mem_word),
      .old_value  (old_reg),
      .merged     (merged)
   );

   always_ff @(posedge mclk) begin
      if (rst)
         merge_done <= 1'b0;
      else if (ce)
         merge_done <= merge_en;
   end

   // writeback pulse two edges after the answer
   always_ff @(posedge mclk) begin
      if (rst)
         wb_valid <= 1'b0;
      else if (ce)
         wb_valid <= merge_done;
   end

   always_ff @(posedge mclk) begin
      if (rst)
         wb_index <= 5'h0;
      else if (ce && merge_done)
         wb_index <= target_reg_field;
   end

   // result register feeds writeback and the forward path
   always_ff @(posedge mclk) begin
      if (rst)
         wb_data <= RESULT_RESET;
      else if (ce && merge_done)
         wb_data <= merged;
   end

   // only the memory-side faults are passed on
   always_ff @(posedge mclk) begin
      if (rst)
         exc_valid <= 1'b0;
      else if (ce)
         exc_valid <= answer && (mem_exception != EXC_NONE);
   end

   // code kept clear between faults
   always_ff @(posedge mclk) begin
      if (rst)
         exc_code <= EXC_NONE;
      else if (ce)
         exc_code <= answer ? mem_exception : EXC_NONE;
   end
endmodule
`default_nettype wire

// >>> uwl_checker.sv
`timescale 1ns/100ps
`default_nettype none
module uwl_checker (
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        instr_valid,
   input wire logic [31:0] instr,
   input wire logic [63:0] base_value,
   input wire logic        mem_valid,
   input wire logic [3:0]  mem_exception,
   input wire logic        mem_req,
   input wire logic [63:0] effective_byte_address,
   input wire logic        wb_valid,
   input wire logic [63:0] wb_data,
   input wire logic        exc_valid,
   input wire logic [3:0]  exc_code,
   input wire logic        busy
);
   import uwl_pkg::*;
   logic is_ld, take, left_reg, done_left;
   assign is_ld = instr[31:26] == OPC_LOAD_LEFT || instr[31:26] == OPC_LOAD_RIGHT;
   assign take = instr_valid && !busy && is_ld;
   // op kept until the answer, since a new load may start the cycle before writeback
   always_ff @(posedge mclk) begin
      if (rst) begin
         left_reg <= 1'b0;
         done_left <= 1'b0;
      end else begin
         if (take) left_reg <= instr[31:26] == OPC_LOAD_LEFT;
         if (busy && mem_valid) done_left <= left_reg;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   a_take_request: assert property (take |=> mem_req && busy)
      else $error("load not started");
   a_ignore_other: assert property (instr_valid && !busy && !is_ld |=> !mem_req)
      else $error("other opcode started");
   a_addr_sum: assert property (take |=> effective_byte_address ==
      $past(base_value) + {{48{$past(instr[15])}}, $past(instr[15:0])}) else $error("bad address");
   a_busy_hold: assert property (busy && !mem_valid |=> busy)
      else $error("busy dropped early");
   a_req_pulse: assert property (mem_req |=> !mem_req)
      else $error("request too long");
   a_wb_timing: assert property (busy && mem_valid && mem_exception == EXC_NONE |-> ##2 wb_valid)
      else $error("writeback late");
   a_exc_report: assert property (busy && mem_valid && mem_exception != EXC_NONE |=>
      exc_valid && exc_code == $past(mem_exception) ##1 !wb_valid) else $error("bad exception");
   a_left_sign: assert property (wb_valid && done_left |-> wb_data[63:32] == {32{wb_data[31]}})
      else $error("left not sign extended");
   c_left: cover property (wb_valid && done_left);
   c_exc: cover property (exc_valid);
   c_fwd: cover property (take && wb_valid);
endmodule
bind unaligned_word_load_merge uwl_checker u_uwl_checker (.mclk, .rst, .instr_valid, .instr,
   .base_value, .mem_valid, .mem_exception, .mem_req, .effective_byte_address, .wb_valid,
   .wb_data, .exc_valid, .exc_code, .busy);
`default_nettype wire

// >>> mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module mem_model (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        mem_req,
   input  wire logic [63:0] addr,
   input  wire logic        big,
   input  wire logic [3:0]  exc_sel,
   input  wire logic        slow,
   output logic             mem_valid,
   output logic      [63:0] mem_doubleword,
   output logic      [3:0]  mem_exception
);
   logic [63:0] a_reg;
   logic [3:0]  e_reg;
   logic [2:0]  cnt;
   // idle lines invert, so a late read never sees the old answer
   always_ff @(posedge mclk) begin
      mem_valid <= 1'b0;
      mem_doubleword <= ~mem_doubleword;
      mem_exception <= ~mem_exception;
      if (rst) begin
         cnt <= 3'h0;
         mem_doubleword <= 64'h0;
      end else if (mem_req) begin
         a_reg <= addr;
         e_reg <= exc_sel;
         cnt <= slow ? 3'h4 : 3'h1;
      end else if (cnt != 3'h0) begin
         cnt <= cnt - 3'h1;
         if (cnt == 3'h1) begin
            mem_valid <= 1'b1;
            mem_exception <= e_reg;
            for (int l = 0; l < 8; l++)
               mem_doubleword[8*l +: 8] <= mb({a_reg[63:3], 3'h0} + 64'(big ? 7 - l : l));
         end
      end
   end
   function automatic logic [7:0] mb(input logic [63:0] a);
      return {a[0], a[7:1]} ^ 8'h5a;
   endfunction
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import uwl_pkg::*;
   logic        mclk, rst, instr_valid, big, slow, mem_req, mem_valid, wb_valid, exc_valid, busy;
   logic [31:0] instr;
   logic [63:0] base_value, eba, mem_dw, wb_data, rf [32], exp_rf [32];
   logic [3:0]  mem_exc, exc_code, exc_sel;
   logic [4:0]  wb_index;
   logic [69:0] q [$], e;
   int          n_fail, comparisons;
   unaligned_word_load_merge u_unaligned_word_load_merge (.mclk, .rst, .ce(1'b1), .instr_valid,
      .instr, .base_value, .target_value(rf[instr[20:16]]), .processor_byte_order_big(big),
      .mem_valid, .mem_doubleword(mem_dw), .mem_exception(mem_exc), .mem_req,
      .effective_byte_address(eba), .wb_valid, .wb_index, .wb_data, .exc_valid, .exc_code, .busy);
   mem_model u_mem_model (.mclk, .rst, .mem_req, .addr(eba), .big, .exc_sel, .slow, .mem_valid,
      .mem_doubleword(mem_dw), .mem_exception(mem_exc));
   function automatic logic [63:0] merge(input bit l, b, input logic [63:0] ad, old);
      logic [31:0] w;
      logic [63:0] a;
      int          n;
      w = old[31:0];
      n = 0;
      for (int j = 0; j < 4; j++) begin
         a = l ? (b ? ad + 3 - j : ad - 3 + j) : (b ? ad - j : ad + j);
         if (a[63:2] == ad[63:2]) begin
            w[8*j +: 8] = {a[0], a[7:1]} ^ 8'h5a;
            n++;
         end
      end
      return (l || n == 4) ? {{32{w[31]}}, w} : {old[63:32], w};
   endfunction
   task automatic chk(input string s, input logic [63:0] x, y);
      comparisons++;
      if (x !== y) begin
         n_fail++;
         $display("MISMATCH %s exp %h got %h", s, x, y);
      end
   endtask
   task automatic end_of_test;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic issue(input bit l, b, input logic [4:0] rt, input logic [15:0] off,
                        input logic [3:0] ex, input bit sl, input bit nw = 1'b0);
      logic [63:0] v;
      v = merge(l, b, 64'h2000 + {{48{off[15]}}, off}, exp_rf[rt]);
      if (ex == 4'h0) exp_rf[rt] = v;
      q.push_back(ex == 4'h0 ? {1'b0, rt, v} : {1'b1, rt, 60'h0, ex});
      if (!nw) @(negedge mclk);
      instr_valid = 1'b1;
      instr = {l ? OPC_LOAD_LEFT : OPC_LOAD_RIGHT, 5'h1, rt, off};
      base_value = 64'h2000;
      big = b;
      exc_sel = ex;
      slow = sl;
      @(negedge mclk);
      instr_valid = 1'b0;
      for (int i = 0; i < 20 && busy !== 1'b0; i++) @(negedge mclk);
      if (busy !== 1'b0) begin
         n_fail++;
         $display("MISMATCH busy exp 0 got %b", busy);
         end_of_test();
      end
   endtask
   task automatic drain;
      for (int i = 0; i < 20 && q.size() > 0; i++) @(negedge mclk);
      if (q.size() > 0) begin
         n_fail++;
         $display("MISMATCH pending exp 0 got %0d", q.size());
         end_of_test();
      end
   endtask
   task automatic t_offsets;
      for (int k = 0; k < 32; k++) begin
         issue(k[3], k[4], 5'(k[2:0] + 1), 16'hfff0 + 16'(k[2:0]), 4'h0, k[0]);
         drain();
      end
      $display("offsets done");
   endtask
   task automatic t_pair;
      for (int k = 0; k < 4; k++) begin
         issue(k[0], k[1], 5'd20, 16'(k[0] == k[1] ? 6 : 9), 4'h0, 1'b0);
         issue(!k[0], k[1], 5'd20, 16'(k[0] != k[1] ? 6 : 9), 4'h0, 1'b0, k[0]);
         drain();
      end
      $display("pair done");
   endtask
   task automatic t_exc;
      @(negedge mclk);
      instr_valid = 1'b1;
      instr = 32'h8c00_0000;
      repeat (2) @(negedge mclk);
      instr_valid = 1'b0;
      for (int c = 1; c < 6; c++) issue(1'b1, 1'b0, 5'd9, 16'h1, 4'(c), 1'b1);
      drain();
      $display("exception done");
   endtask
   always @(negedge mclk) begin
      if (wb_valid === 1'b1 || exc_valid === 1'b1) begin
         if (q.size() == 0) chk("spare", 64'h0, 64'h1);
         else begin
            e = q.pop_front();
            chk("kind", {63'h0, e[69]}, {63'h0, exc_valid});
            if (e[69]) chk("code", e[63:0], {60'h0, exc_code});
            else begin
               chk("index", {59'h0, e[68:64]}, {59'h0, wb_index});
               chk("data", e[63:0], wb_data);
               rf[e[68:64]] = e[63:0];
            end
         end
      end
   end
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   initial begin
      {rst, instr_valid, big, slow, instr, base_value, exc_sel, n_fail, comparisons} = '0;
      rst = 1'b1;
      for (int i = 0; i < 32; i++) rf[i] = 64'h5a5a_0f0f_c3c3_9696 + 64'(i);
      exp_rf = rf;
      repeat (2) @(negedge mclk);
      rst = 1'b0;
      t_offsets();
      t_pair();
      t_exc();
      end_of_test();
   end
endmodule
`default_nettype wire
